// ### rtl/tsa_pkg.sv
// How it works
// - length field is two bytes wide
// - signature is exactly four bytes
// - source address enters little-endian
// - signed data: header, address, counter, status
// - signed data length always eleven bytes
// - counter starts zero, increments per new telegram
// - repeats of one telegram share counter
// - receiver rejects counter not above highest accepted, per source, for the last NSRC sources stored
// - counter enters as four little-endian bytes
// - device-unique sixteen-byte key signs telegrams
// - receiver takes fields from telegram, key separately
// - button sequence sends key-disclosing commissioning telegram
// - nonce: address, address, counter, 0x05
// - counter block 0x01, auth block 0x49 framing
// - second block: length, eleven bytes, zero pad
// - tag from three encryptions, two xors
package tsa_pkg;

  // ****************************************
  // sizes and fixed values
  // ****************************************
  localparam int TG_BITS = 120;
  localparam int DATA_BITS = 88;
  localparam int SIG_BITS = 32;
  localparam logic [3:0] AES_FIRST = 4'h1;
  localparam logic [3:0] AES_LAST = 4'ha;
  localparam logic [7:0] COUNTER_BLOCK_FLAG = 8'h01;
  localparam logic [7:0] AUTH_BLOCK_FLAG = 8'h49;
  localparam logic [7:0] NONCE_TAIL = 8'h05;
  localparam logic [15:0] AUTH_LEN_FIELD = 16'h000b;
  localparam logic [15:0] TG_HEADER = 16'h8c30;
  localparam logic [31:0] SEQ_RESET = 32'h0000_0000;
  // telegram field positions, byte 0 at the top
  localparam int SRC_POS = 72;
  localparam int SEQ_POS = 40;
  localparam int STAT_POS = 32;

  typedef enum logic [1:0] {CCM_IDLE, CCM_X1, CCM_X2, CCM_S0} tsa_ccm_e;

  // ****************************************
  // byte order and aes helpers
  // ****************************************
  function automatic logic [31:0] le32(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  function automatic logic [7:0] xtime(input logic [7:0] b);
    return {b[6:0], 1'b0} ^ (b[7] ? 8'h1b : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xtime(x);
    end
    return p;
  endfunction

  // inverse as b^254, then the affine map
  function automatic logic [7:0] sbox(input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h01;
    p = b;
    for (int i = 1; i < 8; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]} ^ 8'h63;
  endfunction

  function automatic logic [7:0] rcon(input logic [3:0] rnd);
    logic [7:0] r;
    r = 8'h01;
    for (int i = 2; i <= 10; i++) begin
      if (rnd >= 4'(i)) r = xtime(r);
    end
    return r;
  endfunction

  function automatic logic [127:0] key_next(input logic [127:0] rk, input logic [3:0] rnd);
    logic [31:0] t;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    t = {sbox(rk[23:16]), sbox(rk[15:8]), sbox(rk[7:0]), sbox(rk[31:24])} ^ {rcon(rnd), 24'h000000};
    w0 = rk[127:96] ^ t;
    w1 = rk[95:64] ^ w0;
    w2 = rk[63:32] ^ w1;
    return {w0, w1, w2, rk[31:0] ^ w2};
  endfunction

  // one aes-128 round; last skips the column mix
  function automatic logic [127:0] aes_round(input logic [127:0] s, input logic [127:0] rk, input logic last);
    logic [7:0] b [16];
    logic [7:0] m [16];
    logic [127:0] o;
    for (int i = 0; i < 16; i++) begin
      b[i] = sbox(s[127 - 8 * ((i % 4) + 4 * (((i / 4) + (i % 4)) % 4)) -: 8]);
    end
    for (int c = 0; c < 4; c++) begin
      if (last) begin
        m[4*c] = b[4*c];
        m[4*c+1] = b[4*c+1];
        m[4*c+2] = b[4*c+2];
        m[4*c+3] = b[4*c+3];
      end else begin
        m[4*c] = xtime(b[4*c]) ^ xtime(b[4*c+1]) ^ b[4*c+1] ^ b[4*c+2] ^ b[4*c+3];
        m[4*c+1] = b[4*c] ^ xtime(b[4*c+1]) ^ xtime(b[4*c+2]) ^ b[4*c+2] ^ b[4*c+3];
        m[4*c+2] = b[4*c] ^ b[4*c+1] ^ xtime(b[4*c+2]) ^ xtime(b[4*c+3]) ^ b[4*c+3];
        m[4*c+3] = xtime(b[4*c]) ^ b[4*c] ^ b[4*c+1] ^ b[4*c+2] ^ xtime(b[4*c+3]);
      end
    end
    for (int i = 0; i < 16; i++) begin
      o[127 - 8 * i -: 8] = m[i];
    end
    return o ^ rk;
  endfunction

  // ****************************************
  // ccm block builders
  // ****************************************
  function automatic logic [103:0] nonce(input logic [31:0] src, input logic [31:0] seq);
    return {le32(src), le32(src), le32(seq), NONCE_TAIL};
  endfunction

  function automatic logic [127:0] blk_a0(input logic [31:0] src, input logic [31:0] seq);
    return {COUNTER_BLOCK_FLAG, nonce(src, seq), 16'h0000};
  endfunction

  function automatic logic [127:0] blk_b0(input logic [31:0] src, input logic [31:0] seq);
    return {AUTH_BLOCK_FLAG, nonce(src, seq), 16'h0000};
  endfunction

  function automatic logic [127:0] blk_b1(input logic [DATA_BITS-1:0] data);
    return {AUTH_LEN_FIELD, data, 24'h000000};
  endfunction

  function automatic logic [DATA_BITS-1:0] auth_data(input logic [31:0] src, input logic [31:0] seq,
                                                     input logic [7:0] status);
    return {TG_HEADER, le32(src), le32(seq), status};
  endfunction

endpackage

// ### rtl/tsa_link_if.sv
`timescale 1ns/1ps
interface tsa_link_if;
  import tsa_pkg::*;
  // data telegram: header, address, counter, status, signature
  logic tg_valid;
  logic [TG_BITS-1:0] tg_data;
  // commissioning telegram
  logic com_valid;
  logic [31:0] com_src;
  logic [127:0] com_key;

  modport tx (output tg_valid, output tg_data, output com_valid, output com_src, output com_key);
  modport rx (input tg_valid, input tg_data, input com_valid, input com_src, input com_key);
endinterface

// ### rtl/tsa_tx.sv
`timescale 1ns/1ps
module tsa_tx import tsa_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // radio side
  tsa_link_if.tx link,
  // switch side
  input wire logic [127:0] key,
  input wire logic [31:0] src_addr,
  input wire logic [7:0] status,
  input wire logic send_new,
  input wire logic send_repeat,
  input wire logic send_commission,
  // state
  output logic busy,
  output logic [31:0] seq_value
);

  // ****************************************
  // state
  // ****************************************
  tsa_ccm_e ccm_q, ccm_d;
  logic [127:0] st_q, st_d;
  logic [127:0] rk_q, rk_d;
  logic [3:0] rnd_q, rnd_d;
  logic [127:0] mac_q, mac_d;
  logic [127:0] a0_q, a0_d;
  logic [127:0] key_q, key_d;
  logic [127:0] ckey_q, ckey_d;
  logic [31:0] src_q, src_d;
  logic [31:0] seq_q, seq_d;
  logic [DATA_BITS-1:0] data_q, data_d;
  logic [TG_BITS-1:0] tg_q, tg_d;
  logic tg_valid_q, tg_valid_d;
  logic com_valid_q, com_valid_d;
  logic have_q, have_d;
  logic busy_q, busy_d;
  logic [127:0] rk_n;
  logic [127:0] res;
  logic [127:0] tag;

  // ****************************************
  // signing sequence
  // ****************************************
  always_comb begin
    ccm_d = ccm_q;
    st_d = st_q;
    rk_d = rk_q;
    rnd_d = rnd_q;
    mac_d = mac_q;
    a0_d = a0_q;
    key_d = key_q;
    ckey_d = ckey_q;
    src_d = src_q;
    seq_d = seq_q;
    data_d = data_q;
    tg_d = tg_q;
    tg_valid_d = 1'b0;
    com_valid_d = 1'b0;
    have_d = have_q;
    busy_d = busy_q;
    rk_n = key_next(rk_q, rnd_q);
    res = aes_round(st_q, rk_n, rnd_q == AES_LAST);
    tag = mac_q ^ res;
    if (ccm_q != CCM_IDLE) begin
      st_d = res;
      rk_d = rk_n;
      rnd_d = 4'(rnd_q + 4'h1);
    end
    case (ccm_q)
      CCM_IDLE: begin
        if (send_commission) begin
          // discloses the key to the receiver; signing key left alone
          ckey_d = key;
          src_d = src_addr;
          com_valid_d = 1'b1;
        end else if (send_new) begin
          seq_d = seq_q + 32'h0000_0001;
          key_d = key;
          data_d = auth_data(src_addr, seq_d, status);
          a0_d = blk_a0(src_addr, seq_d);
          st_d = blk_b0(src_addr, seq_d) ^ key;
          rk_d = key;
          rnd_d = AES_FIRST;
          busy_d = 1'b1;
          ccm_d = CCM_X1;
        end else if (send_repeat && have_q) begin
          tg_valid_d = 1'b1;
        end
      end
      CCM_X1: begin
        if (rnd_q == AES_LAST) begin
          st_d = res ^ blk_b1(data_q) ^ key_q;
          rk_d = key_q;
          rnd_d = AES_FIRST;
          ccm_d = CCM_X2;
        end
      end
      CCM_X2: begin
        if (rnd_q == AES_LAST) begin
          mac_d = res;
          st_d = a0_q ^ key_q;
          rk_d = key_q;
          rnd_d = AES_FIRST;
          ccm_d = CCM_S0;
        end
      end
      CCM_S0: begin
        if (rnd_q == AES_LAST) begin
          tg_d = {data_q, tag[127:128-SIG_BITS]};
          tg_valid_d = 1'b1;
          have_d = 1'b1;
          busy_d = 1'b0;
          ccm_d = CCM_IDLE;
        end
      end
      default: begin
        busy_d = 1'b0;
        ccm_d = CCM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ccm_q <= CCM_IDLE;
      st_q <= '0;
      rk_q <= '0;
      rnd_q <= AES_FIRST;
      mac_q <= '0;
      a0_q <= '0;
      key_q <= '0;
      ckey_q <= '0;
      src_q <= '0;
      seq_q <= SEQ_RESET;
      data_q <= '0;
      tg_q <= '0;
      tg_valid_q <= 1'b0;
      com_valid_q <= 1'b0;
      have_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      ccm_q <= ccm_d;
      st_q <= st_d;
      rk_q <= rk_d;
      rnd_q <= rnd_d;
      mac_q <= mac_d;
      a0_q <= a0_d;
      key_q <= key_d;
      ckey_q <= ckey_d;
      src_q <= src_d;
      seq_q <= seq_d;
      data_q <= data_d;
      tg_q <= tg_d;
      tg_valid_q <= tg_valid_d;
      com_valid_q <= com_valid_d;
      have_q <= have_d;
      busy_q <= busy_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.tg_valid = tg_valid_q;
  assign link.tg_data = tg_q;
  assign link.com_valid = com_valid_q;
  assign link.com_src = src_q;
  assign link.com_key = ckey_q;
  assign busy = busy_q;
  assign seq_value = seq_q;

endmodule // tsa_tx

// ### rtl/tsa_rx.sv
`timescale 1ns/1ps
module tsa_rx import tsa_pkg::*; #(
  parameter int NSRC = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // radio side
  tsa_link_if.rx link,
  // key store side
  input wire logic [127:0] key,
  // verdict
  output logic busy,
  output logic res_valid,
  output logic res_pass,
  output logic res_sig_ok,
  output logic res_fresh,
  output logic [31:0] res_src,
  output logic [31:0] res_seq,
  output logic [7:0] res_status,
  // commissioning
  output logic learned_valid,
  output logic [31:0] learned_src,
  output logic [127:0] learned_key
);

  localparam int IW = (NSRC > 1) ? $clog2(NSRC) : 1;

  // ****************************************
  // state
  // ****************************************
  tsa_ccm_e ccm_q, ccm_d;
  logic [127:0] st_q, st_d;
  logic [127:0] rk_q, rk_d;
  logic [3:0] rnd_q, rnd_d;
  logic [127:0] mac_q, mac_d;
  logic [127:0] key_q, key_d;
  logic [TG_BITS-1:0] tg_q, tg_d;
  logic [31:0] src_tab_q [NSRC];
  logic [31:0] src_tab_d [NSRC];
  logic [31:0] seq_tab_q [NSRC];
  logic [31:0] seq_tab_d [NSRC];
  logic [NSRC-1:0] used_q, used_d;
  logic [IW-1:0] ptr_q, ptr_d;
  logic busy_q, busy_d;
  logic res_valid_q, res_valid_d;
  logic pass_q, pass_d;
  logic sig_ok_q, sig_ok_d;
  logic fresh_q, fresh_d;
  logic lrn_valid_q, lrn_valid_d;
  logic [31:0] lrn_src_q, lrn_src_d;
  logic [127:0] lrn_key_q, lrn_key_d;
  logic [127:0] rk_n;
  logic [127:0] res;
  logic [127:0] tag;
  logic [31:0] t_src;
  logic [31:0] t_seq;
  logic hit;
  logic [IW-1:0] hit_idx;
  logic [31:0] hit_seq;

  // fields come out of the telegram itself
  assign t_src = le32(tg_q[SRC_POS +: 32]);
  assign t_seq = le32(tg_q[SEQ_POS +: 32]);

  // ****************************************
  // checking sequence
  // ****************************************
  always_comb begin
    ccm_d = ccm_q;
    st_d = st_q;
    rk_d = rk_q;
    rnd_d = rnd_q;
    mac_d = mac_q;
    key_d = key_q;
    tg_d = tg_q;
    src_tab_d = src_tab_q;
    seq_tab_d = seq_tab_q;
    used_d = used_q;
    ptr_d = ptr_q;
    busy_d = busy_q;
    res_valid_d = 1'b0;
    pass_d = pass_q;
    sig_ok_d = sig_ok_q;
    fresh_d = fresh_q;
    lrn_valid_d = 1'b0;
    lrn_src_d = lrn_src_q;
    lrn_key_d = lrn_key_q;
    hit = 1'b0;
    hit_idx = '0;
    hit_seq = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (used_q[i] && src_tab_q[i] == t_src && !hit) begin
        hit = 1'b1;
        hit_idx = IW'(i);
        hit_seq = seq_tab_q[i];
      end
    end
    rk_n = key_next(rk_q, rnd_q);
    res = aes_round(st_q, rk_n, rnd_q == AES_LAST);
    tag = mac_q ^ res;
    if (link.com_valid) begin
      lrn_valid_d = 1'b1;
      lrn_src_d = link.com_src;
      lrn_key_d = link.com_key;
    end
    if (ccm_q != CCM_IDLE) begin
      st_d = res;
      rk_d = rk_n;
      rnd_d = 4'(rnd_q + 4'h1);
    end
    case (ccm_q)
      CCM_IDLE: begin
        if (link.tg_valid) begin
          tg_d = link.tg_data;
          key_d = key;
          st_d = blk_b0(le32(link.tg_data[SRC_POS +: 32]), le32(link.tg_data[SEQ_POS +: 32])) ^ key;
          rk_d = key;
          rnd_d = AES_FIRST;
          busy_d = 1'b1;
          ccm_d = CCM_X1;
        end
      end
      CCM_X1: begin
        if (rnd_q == AES_LAST) begin
          st_d = res ^ blk_b1(tg_q[TG_BITS-1:SIG_BITS]) ^ key_q;
          rk_d = key_q;
          rnd_d = AES_FIRST;
          ccm_d = CCM_X2;
        end
      end
      CCM_X2: begin
        if (rnd_q == AES_LAST) begin
          mac_d = res;
          st_d = blk_a0(t_src, t_seq) ^ key_q;
          rk_d = key_q;
          rnd_d = AES_FIRST;
          ccm_d = CCM_S0;
        end
      end
      CCM_S0: begin
        if (rnd_q == AES_LAST) begin
          sig_ok_d = tag[127:128-SIG_BITS] == tg_q[SIG_BITS-1:0];
          fresh_d = !hit || (t_seq > hit_seq);
          pass_d = sig_ok_d && fresh_d;
          if (sig_ok_d && fresh_d) begin
            if (hit) begin
              seq_tab_d[hit_idx] = t_seq;
            end else begin
              src_tab_d[ptr_q] = t_src;
              seq_tab_d[ptr_q] = t_seq;
              used_d[ptr_q] = 1'b1;
              ptr_d = (ptr_q == IW'(NSRC - 1)) ? '0 : IW'(ptr_q + 1'b1);
            end
          end
          res_valid_d = 1'b1;
          busy_d = 1'b0;
          ccm_d = CCM_IDLE;
        end
      end
      default: begin
        busy_d = 1'b0;
        ccm_d = CCM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ccm_q <= CCM_IDLE;
      st_q <= '0;
      rk_q <= '0;
      rnd_q <= AES_FIRST;
      mac_q <= '0;
      key_q <= '0;
      tg_q <= '0;
      for (int i = 0; i < NSRC; i++) begin
        src_tab_q[i] <= '0;
        seq_tab_q[i] <= SEQ_RESET;
      end
      used_q <= '0;
      ptr_q <= '0;
      busy_q <= 1'b0;
      res_valid_q <= 1'b0;
      pass_q <= 1'b0;
      sig_ok_q <= 1'b0;
      fresh_q <= 1'b0;
      lrn_valid_q <= 1'b0;
      lrn_src_q <= '0;
      lrn_key_q <= '0;
    end else begin
      ccm_q <= ccm_d;
      st_q <= st_d;
      rk_q <= rk_d;
      rnd_q <= rnd_d;
      mac_q <= mac_d;
      key_q <= key_d;
      tg_q <= tg_d;
      src_tab_q <= src_tab_d;
      seq_tab_q <= seq_tab_d;
      used_q <= used_d;
      ptr_q <= ptr_d;
      busy_q <= busy_d;
      res_valid_q <= res_valid_d;
      pass_q <= pass_d;
      sig_ok_q <= sig_ok_d;
      fresh_q <= fresh_d;
      lrn_valid_q <= lrn_valid_d;
      lrn_src_q <= lrn_src_d;
      lrn_key_q <= lrn_key_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign busy = busy_q;
  assign res_valid = res_valid_q;
  assign res_pass = pass_q;
  assign res_sig_ok = sig_ok_q;
  assign res_fresh = fresh_q;
  assign res_src = t_src;
  assign res_seq = t_seq;
  assign res_status = tg_q[STAT_POS +: 8];
  assign learned_valid = lrn_valid_q;
  assign learned_src = lrn_src_q;
  assign learned_key = lrn_key_q;

endmodule // tsa_rx

// ### tb/tsa_link_assertions.sv
`timescale 1ns/1ps
module tsa_link_assertions import tsa_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // link
  input wire logic tg_valid,
  input wire logic [TG_BITS-1:0] tg_data,
  input wire logic com_valid,
  input wire logic [31:0] com_src,
  input wire logic [127:0] com_key
);
  // ****************************************
  // history of the last telegram
  // ****************************************
  logic seen_q;
  logic seen_d;
  logic [TG_BITS-1:0] last_q;
  logic [TG_BITS-1:0] last_d;
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  logic [31:0] seq_w;
  logic [31:0] lseq_w;
  logic fresh_w;

  assign seq_w = {tg_data[47:40], tg_data[55:48], tg_data[63:56], tg_data[71:64]};
  assign lseq_w = {last_q[47:40], last_q[55:48], last_q[63:56], last_q[71:64]};
  assign fresh_w = tg_valid && (!seen_q || seq_w != lseq_w);

  always_comb begin
    seen_d = seen_q | tg_valid;
    last_d = tg_valid ? tg_data : last_q;
    gap_d = fresh_w ? 8'h00 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      seen_q <= 1'b0;
      last_q <= '0;
      gap_q <= 8'hff;
    end else begin
      seen_q <= seen_d;
      last_q <= last_d;
      gap_q <= gap_d;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_header_fixed: assert property (tg_valid |-> tg_data[119:104] == TG_HEADER)
    else $error("telegram header wrong");
  chk_first_seq: assert property (tg_valid && !seen_q |-> seq_w == 32'h0000_0001)
    else $error("first counter not one");
  chk_seq_step: assert property (tg_valid && seen_q |-> seq_w == lseq_w || seq_w == lseq_w + 32'h1)
    else $error("counter step wrong");
  chk_repeat_same: assert property (tg_valid && seen_q && seq_w == lseq_w |-> tg_data == last_q)
    else $error("repeat differs");
  chk_sig_rolls: assert property (fresh_w && seen_q |-> tg_data[31:0] != last_q[31:0])
    else $error("signature did not change");
  chk_new_spacing: assert property (fresh_w && seen_q |-> gap_q >= 8'd30)
    else $error("new telegrams too close");
  chk_tg_hold: assert property ($changed(tg_data) |-> tg_valid)
    else $error("telegram changed without valid");
  chk_com_hold: assert property ($changed(com_key) || $changed(com_src) |-> com_valid)
    else $error("commission changed without valid");
endmodule // tsa_link_assertions

// ### tb/telegram_signature_auth_tb_top.sv
`timescale 1ns/1ps
module telegram_signature_auth_tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [127:0] key = 128'hd8f7048d01f7aaeec0a757b862f96301;
  logic [127:0] key2 = '0;
  logic [31:0] src = 32'h1a2b3c4d;
  logic [7:0] status = 8'h00;
  logic send_new = 1'b0;
  logic send_repeat = 1'b0;
  logic send_commission = 1'b0;
  logic busy, r1_busy, r1_valid, r1_pass, r1_ok, r1_fresh, lv, r2_valid, r2_pass, r2_ok, r2_fresh;
  logic [31:0] seq_value, r1_src, r1_seq, lsrc;
  logic [7:0] r1_st;
  logic [127:0] lkey;
  int mismatches = 0;
  int checks_done = 0;
  int tg_cnt = 0;
  int pos[6] = '{0, 31, 32, 40, 72, 104};

  always #5 clk_sys = ~clk_sys;

  tsa_link_if lk ();
  tsa_link_if lk2 ();
  always @(posedge clk_sys) if (lk.tg_valid === 1'b1) tg_cnt <= tg_cnt + 1;
  tsa_tx i_tsa_tx (.clk_sys(clk_sys), .rstn(rstn), .link(lk.tx), .key(key), .src_addr(src), .status(status),
    .send_new(send_new), .send_repeat(send_repeat), .send_commission(send_commission), .busy(busy),
    .seq_value(seq_value));
  tsa_rx i_tsa_rx (.clk_sys(clk_sys), .rstn(rstn), .link(lk.rx), .key(key), .busy(r1_busy), .res_valid(r1_valid),
    .res_pass(r1_pass), .res_sig_ok(r1_ok), .res_fresh(r1_fresh), .res_src(r1_src), .res_seq(r1_seq),
    .res_status(r1_st), .learned_valid(lv), .learned_src(lsrc), .learned_key(lkey));
  tsa_rx i_tsa_rx_b (.clk_sys(clk_sys), .rstn(rstn), .link(lk2.rx), .key(key2), .busy(), .res_valid(r2_valid),
    .res_pass(r2_pass), .res_sig_ok(r2_ok), .res_fresh(r2_fresh), .res_src(), .res_seq(), .res_status(),
    .learned_valid(), .learned_src(), .learned_key());
  tsa_link_assertions i_tsa_link_assertions (.clk_sys(clk_sys), .rstn(rstn), .tg_valid(lk.tg_valid),
    .tg_data(lk.tg_data), .com_valid(lk.com_valid), .com_src(lk.com_src), .com_key(lk.com_key));

  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [31:0] sw(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction

  task automatic chk(input string name, input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // kind 0 new, 1 repeat, 2 commission
  task automatic tx_op(input int kind);
    @(negedge clk_sys);
    send_new = (kind == 0);
    send_repeat = (kind == 1);
    send_commission = (kind == 2);
    @(negedge clk_sys);
    send_new = 1'b0;
    send_repeat = 1'b0;
    send_commission = 1'b0;
  endtask

  task automatic wait_tg(output logic [119:0] t);
    int n;
    n = 0;
    while (lk.tg_valid !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk("telegram arrival", n < 40, 1);
    t = lk.tg_data;
  endtask

  task automatic rx_wait(input bit b, output logic [2:0] v);
    int n;
    n = 0;
    while ((b ? r2_valid : r1_valid) !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk("verdict arrival", n < 40, 1);
    v = b ? {r2_pass, r2_ok, r2_fresh} : {r1_pass, r1_ok, r1_fresh};
  endtask

  task automatic drv2(input logic [119:0] t, input logic [127:0] k, output logic [2:0] v);
    @(negedge clk_sys);
    key2 = k;
    lk2.tg_data = t;
    lk2.tg_valid = 1'b1;
    @(negedge clk_sys);
    lk2.tg_valid = 1'b0;
    rx_wait(1, v);
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end

  initial begin
    logic [119:0] tg;
    logic [119:0] prev;
    logic [119:0] t1;
    logic [2:0] v;
    logic [127:0] aes_s;
    logic [127:0] aes_k;
    lk2.tg_valid = 1'b0;
    lk2.tg_data = '0;
    lk2.com_valid = 1'b0;
    lk2.com_src = '0;
    lk2.com_key = '0;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    chk("counter at reset", seq_value, 0);
    chk("idle at reset", {busy, r1_busy, lk.tg_valid}, 0);
    // fixed cipher vector, independent of both ends
    aes_s = 128'h58b72a47f7db7f731687693defe53456 ^ key;
    aes_k = key;
    for (int r = 1; r <= 10; r++) begin
      aes_k = tsa_pkg::key_next(aes_k, 4'(r));
      aes_s = tsa_pkg::aes_round(aes_s, aes_k, r == 10);
    end
    chk("cipher vector", aes_s, 128'ha0631db5e8d9d267a61fc4f48551d608);
    tx_op(1);
    repeat (3) @(negedge clk_sys);
    chk("early repeat", tg_cnt, 0);
    for (int i = 1; i <= 3; i++) begin
      status = {4'(i), 4'h3};
      tx_op(0);
      chk("signing busy", busy, 1);
      if (i == 2) tx_op(0);
      wait_tg(tg);
      @(negedge clk_sys);
      chk("checker busy", r1_busy, 1);
      chk("telegram body", tg[119:32], {16'h8c30, sw(src), sw(32'(i)), status});
      chk("counter", seq_value, i);
      if (i > 1) chk("signature rolls", tg[31:0] != prev[31:0], 1);
      rx_wait(0, v);
      chk("verdict", v, 3'b111);
      chk("fields", {r1_src, r1_seq, r1_st}, {src, 32'(i), status});
      if (i == 1) t1 = tg;
      prev = tg;
    end
    tx_op(1);
    wait_tg(tg);
    chk("repeat copy", tg, prev);
    rx_wait(0, v);
    chk("replay verdict", v, 3'b010);
    tx_op(2);
    chk("com src", {lk.com_valid, lk.com_src}, {1'b1, src});
    chk("com key", lk.com_key, key);
    @(negedge clk_sys);
    chk("learned src", {lv, lsrc}, {1'b1, src});
    chk("learned key", lkey, key);
    chk("telegram count", tg_cnt, 4);
    foreach (pos[j]) begin
      drv2(prev ^ (120'h1 << pos[j]), key, v);
      chk("tampered", v, 3'b001);
    end
    drv2(prev, key ^ 128'h1, v);
    chk("wrong key", v, 3'b001);
    drv2(prev, key, v);
    chk("genuine", v, 3'b111);
    drv2(prev, key, v);
    chk("same counter", v, 3'b010);
    drv2(t1, key, v);
    chk("older counter", v, 3'b010);
    summarize();
  end
endmodule // telegram_signature_auth_tb_top
